// ==== shared/acm_defs.svh ====
// register offsets, field positions and reset values of the comparator event block
`ifndef ACM_DEFS_SVH
`define ACM_DEFS_SVH

// register byte offsets
`define ACM_OFS_MUX_CTRL   8'h00
`define ACM_OFS_CTRL_STAT  8'h04
`define ACM_OFS_BUF_DIS    8'h08
`define ACM_OFS_IRQ_STAT   8'h0C
`define ACM_OFS_IRQ_CLEAR  8'h10
`define ACM_OFS_IRQ_EN     8'h14

// control and status field positions
`define ACM_CS_POWER_OFF   7
`define ACM_CS_BANDGAP     6
`define ACM_CS_RESULT      5
`define ACM_CS_FLAG        4
`define ACM_CS_IRQ_EN      3
`define ACM_CS_CAPTURE     2
`define ACM_CS_MODE_HI     1
`define ACM_CS_MODE_LO     0

// multiplexer control field positions
`define ACM_MX_MUX_EN      6
`define ACM_MX_TRIG_HI     2
`define ACM_MX_TRIG_LO     0

// buffer disable field positions
`define ACM_BD_NEG         1
`define ACM_BD_POS         0

// interrupt register field position
`define ACM_IRQ_EVENT      0

// reset values
`define ACM_RST_BYTE       8'h00
`define ACM_RST_MODE       2'h0
`define ACM_RST_TRIG       3'h0
`define ACM_RST_BUF        2'h0

`endif

// ==== shared/acm_pkg.sv ====
// types shared by the comparator event block
`default_nettype none
package acm_pkg;

  // event mode field encodings
  typedef enum logic [1:0] {
    ACM_MODE_TOGGLE = 2'b00,
    ACM_MODE_RSVD   = 2'b01,
    ACM_MODE_FALL   = 2'b10,
    ACM_MODE_RISE   = 2'b11
  } acm_mode_e;

  // controls handed to the analog comparator and its input muxes
  typedef struct packed {
    logic       power_off;     // comparator supply switched off
    logic       bandgap_pos;   // reference replaces positive pin
    logic       neg_from_chan; // negative input taken from channel mux
    logic [2:0] neg_channel;   // analog channel used when above is set
    logic       neg_buf_off;   // negative pin digital buffer off
    logic       pos_buf_off;   // positive pin digital buffer off
  } acm_analog_s;

endpackage : acm_pkg
`default_nettype wire

// ==== hw/acm_sync.sv ====
// two-flop synchroniser for levels arriving from outside the clock domain
`default_nettype none
module acm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg; // first stage, read only by second stage

  // two stages; only the second stage is visible to logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : acm_sync
`default_nettype wire

// ==== hw/acm_edge.sv ====
// edge detector producing a one-cycle event for the selected comparator mode
`default_nettype none
`include "acm_defs.svh"
module acm_edge
  import acm_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire logic      level_in,
  input  wire acm_mode_e mode,
  output logic           event_pulse
);

  logic prev_reg; // level seen one cycle earlier
  logic rise;     // low to high this cycle
  logic fall;     // high to low this cycle

  // remember last cycle's level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level_in;
    end
  end

  assign rise = level_in & ~prev_reg;
  assign fall = ~level_in & prev_reg;

  // pick the event the mode asks for
  always_comb begin
    unique case (mode)
      ACM_MODE_TOGGLE: event_pulse = rise | fall;
      ACM_MODE_RSVD:   event_pulse = 1'b0;        // reserved, no event
      ACM_MODE_FALL:   event_pulse = fall;
      ACM_MODE_RISE:   event_pulse = rise;
    endcase
  end

endmodule : acm_edge
`default_nettype wire

// ==== hw/acm_top.sv ====
// comparator event control: apb registers, sync, events, interrupt, mux steering
//
// The register offsets and the APB register port are this design's own decisions.
`default_nettype none
`include "acm_defs.svh"
module acm_top
  import acm_pkg::*;
(
  input  wire logic        pclk,                       // system clock
  input  wire logic        presetn,                    // async reset, low
  input  wire logic        psel,                       // apb select
  input  wire logic        penable,                    // apb access phase
  input  wire logic        pwrite,                     // apb direction
  input  wire logic [7:0]  paddr,                      // apb byte address
  input  wire logic [31:0] pwdata,                     // apb write data
  output logic      [31:0] prdata,                     // apb read data
  output logic             pready,                     // apb ready
  output logic             pslverr,                    // apb error
  input  wire logic        comp_raw,                   // analog comparator output
  input  wire logic [1:0]  pin_digital_in,             // pin buffers, neg/pos
  input  wire logic        converter_enable,           // converter is on
  input  wire logic [2:0]  channel_select_bits,        // converter channel field
  input  wire logic        global_irq_enable,          // cpu global enable
  input  wire logic        irq_ack,                    // vector taken pulse
  output acm_analog_s      analog_ctrl,                // controls to analog side
  output logic             capture_out,                // to timer capture front end
  output logic [1:0]       pin_digital_read,           // port input bits
  output logic [2:0]       auto_trigger_source_select, // to converter
  output logic             irq                         // interrupt request
);

  // ------------------------------------------------------------------
  // software-visible state
  // ------------------------------------------------------------------
  logic       mux_en_reg;     // negative mux enable
  logic [2:0] trig_reg;       // converter trigger source field
  logic       power_off_reg;  // comparator power off
  logic       bandgap_reg;    // bandgap on positive input
  logic       flag_reg;       // sticky compare event flag
  logic       irq_en_reg;     // compare interrupt enable
  logic       capture_reg;    // capture route enable
  acm_mode_e  mode_reg;       // event mode
  logic [1:0] buf_dis_reg;    // pin buffer disable bits

  // ------------------------------------------------------------------
  // internal signals
  // ------------------------------------------------------------------
  logic       comp_sync;      // synchronised comparator output
  logic [1:0] pin_sync;       // synchronised pin levels
  logic       result;         // readable compare result
  logic       event_pulse;    // selected event this cycle
  logic       setup;          // apb setup phase
  logic       wr_access;      // write taking effect this edge
  logic       flag_clear;     // any clear request this cycle
  logic       cs_wr;          // write to control/status
  logic [7:0] cs_wbyte;       // low byte of write data
  logic [31:0] rd_value;      // read mux output
  logic       addr_ok;        // address maps to a register

  // true when the address hits the given register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // true when the address hits any mapped register
  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, `ACM_OFS_MUX_CTRL) | hit(a, `ACM_OFS_CTRL_STAT) |
             hit(a, `ACM_OFS_BUF_DIS)  | hit(a, `ACM_OFS_IRQ_STAT)  |
             hit(a, `ACM_OFS_IRQ_CLEAR) | hit(a, `ACM_OFS_IRQ_EN);
  endfunction : mapped

  // ------------------------------------------------------------------
  // synchronisers for pin-side levels
  // ------------------------------------------------------------------
  acm_sync #(
    .WIDTH (1)
  ) u_comp_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (comp_raw),
    .sync_out (comp_sync)
  );

  acm_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pin_digital_in),
    .sync_out (pin_sync)
  );

  // a powered-off comparator reports low; the analog output is meaningless
  assign result = comp_sync & ~power_off_reg;

  // ------------------------------------------------------------------
  // event detection
  // ------------------------------------------------------------------
  acm_edge u_edge (
    .pclk        (pclk),
    .presetn     (presetn),
    .level_in    (result),
    .mode        (mode_reg),
    .event_pulse (event_pulse)
  );

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  assign setup     = psel & ~penable;
  assign wr_access = psel & penable & pwrite & pready;
  assign cs_wr     = wr_access & hit(paddr, `ACM_OFS_CTRL_STAT);
  assign cs_wbyte  = pwdata[7:0];
  assign addr_ok   = mapped(paddr);

  // zero-wait slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  // unmapped addresses answer with an error and no side effect
  assign pslverr = psel & penable & ~addr_ok;

  // ------------------------------------------------------------------
  // multiplexer control register
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_en_reg <= 1'b0;
      trig_reg   <= `ACM_RST_TRIG;
    end else if (wr_access && hit(paddr, `ACM_OFS_MUX_CTRL)) begin
      mux_en_reg <= pwdata[`ACM_MX_MUX_EN];
      trig_reg   <= pwdata[`ACM_MX_TRIG_HI:`ACM_MX_TRIG_LO];
    end
  end

  // ------------------------------------------------------------------
  // control/status register fields other than the flag
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_off_reg <= 1'b0;
      bandgap_reg   <= 1'b0;
      irq_en_reg    <= 1'b0;
      capture_reg   <= 1'b0;
      mode_reg      <= ACM_MODE_TOGGLE;
    end else if (cs_wr) begin
      // power off may change any time; software masks the irq first
      power_off_reg <= cs_wbyte[`ACM_CS_POWER_OFF];
      bandgap_reg   <= cs_wbyte[`ACM_CS_BANDGAP];
      irq_en_reg    <= cs_wbyte[`ACM_CS_IRQ_EN];
      capture_reg   <= cs_wbyte[`ACM_CS_CAPTURE];
      mode_reg      <= acm_mode_e'(cs_wbyte[`ACM_CS_MODE_HI:`ACM_CS_MODE_LO]);
    end else if (wr_access && hit(paddr, `ACM_OFS_IRQ_EN)) begin
      // the enable register is an alias of the enable field
      irq_en_reg    <= pwdata[`ACM_IRQ_EVENT];
    end
  end

  // ------------------------------------------------------------------
  // sticky event flag
  // ------------------------------------------------------------------
  // cleared by vector taken, write-one to the flag, or the clear register
  assign flag_clear = irq_ack |
                      (cs_wr & cs_wbyte[`ACM_CS_FLAG]) |
                      (wr_access & hit(paddr, `ACM_OFS_IRQ_CLEAR) &
                       pwdata[`ACM_IRQ_EVENT]);

  // a new event in the clearing cycle keeps the flag set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;
    end else if (event_pulse) begin
      flag_reg <= 1'b1;
    end else if (flag_clear) begin
      flag_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // buffer disable register
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_dis_reg <= `ACM_RST_BUF;
    end else if (wr_access && hit(paddr, `ACM_OFS_BUF_DIS)) begin
      // only the two low bits hold state; the rest are not stored
      buf_dis_reg <= pwdata[`ACM_BD_NEG:`ACM_BD_POS];
    end
  end

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  always_comb begin
    rd_value = '0;
    if (hit(paddr, `ACM_OFS_MUX_CTRL)) begin
      rd_value[`ACM_MX_MUX_EN]                 = mux_en_reg;
      rd_value[`ACM_MX_TRIG_HI:`ACM_MX_TRIG_LO] = trig_reg;
    end else if (hit(paddr, `ACM_OFS_CTRL_STAT)) begin
      rd_value[`ACM_CS_POWER_OFF] = power_off_reg;
      rd_value[`ACM_CS_BANDGAP]   = bandgap_reg;
      rd_value[`ACM_CS_RESULT]    = result;
      rd_value[`ACM_CS_FLAG]      = flag_reg;
      rd_value[`ACM_CS_IRQ_EN]    = irq_en_reg;
      rd_value[`ACM_CS_CAPTURE]   = capture_reg;
      rd_value[`ACM_CS_MODE_HI:`ACM_CS_MODE_LO] = mode_reg;
    end else if (hit(paddr, `ACM_OFS_BUF_DIS)) begin
      // upper bits stay zero
      rd_value[`ACM_BD_NEG:`ACM_BD_POS] = buf_dis_reg;
    end else if (hit(paddr, `ACM_OFS_IRQ_STAT)) begin
      rd_value[`ACM_IRQ_EVENT] = flag_reg;
    end else if (hit(paddr, `ACM_OFS_IRQ_EN)) begin
      rd_value[`ACM_IRQ_EVENT] = irq_en_reg;
    end
    // clear register and unmapped addresses read zero
  end

  // read data captured in the setup phase, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup && !pwrite) begin
      prdata <= rd_value;
    end
  end

  // ------------------------------------------------------------------
  // interrupt request
  // ------------------------------------------------------------------
  // level request while flag, local enable and global enable all set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= flag_reg & irq_en_reg & global_irq_enable;
    end
  end

  // ------------------------------------------------------------------
  // capture routing
  // ------------------------------------------------------------------
  // the timer front end applies its own filter and edge choice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_out <= 1'b0;
    end else begin
      capture_out <= capture_reg & result;
    end
  end

  // ------------------------------------------------------------------
  // port input bits
  // ------------------------------------------------------------------
  // a disabled buffer reads as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_digital_read <= '0;
    end else begin
      pin_digital_read <= pin_sync & ~buf_dis_reg;
    end
  end

  // ------------------------------------------------------------------
  // analog steering
  // ------------------------------------------------------------------
  // channel mux only reaches the comparator while the converter is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_ctrl <= '0;
    end else begin
      analog_ctrl.power_off     <= power_off_reg;
      analog_ctrl.bandgap_pos   <= bandgap_reg;
      analog_ctrl.neg_from_chan <= mux_en_reg & ~converter_enable;
      analog_ctrl.neg_channel   <= channel_select_bits;
      analog_ctrl.neg_buf_off   <= buf_dis_reg[`ACM_BD_NEG];
      analog_ctrl.pos_buf_off   <= buf_dis_reg[`ACM_BD_POS];
    end
  end

  // trigger source field handed to the converter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_trigger_source_select <= `ACM_RST_TRIG;
    end else begin
      auto_trigger_source_select <= trig_reg;
    end
  end

endmodule : acm_top
`default_nettype wire

// ==== sim/acm_top_sva.sv ====
// port-level assertions and covers for the comparator event block
`default_nettype none
module acm_top_sva
  import acm_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        comp_raw,
  input wire logic        converter_enable,
  input wire logic [2:0]  channel_select_bits,
  input wire logic        global_irq_enable,
  input wire logic        irq_ack,
  input wire acm_analog_s analog_ctrl,
  input wire logic        capture_out,
  input wire logic [1:0]  pin_digital_read,
  input wire logic [2:0]  auto_trigger_source_select,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire        acc = psel && penable; // apb access phase
  logic [2:0] quiet_cnt;             // cycles since comparator or power last moved
  // count quiet cycles so that no edge event can be in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_cnt <= 3'h0;
    end else if ($changed(comp_raw) || $changed(analog_ctrl.power_off)) begin
      quiet_cnt <= 3'h0;
    end else if (quiet_cnt != 3'h7) begin
      quiet_cnt <= quiet_cnt + 3'h1;
    end
  end
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (acc && paddr > 8'h14 |-> pslverr) else $error("no slverr");
  a_err_idle: assert property (!acc |-> !pslverr) else $error("slverr outside access");
  a_irq_global: assert property (irq |-> $past(global_irq_enable))
    else $error("irq without global enable");
  a_irq_ack_drop: assert property (irq && irq_ack && quiet_cnt == 3'h7 |=> ##1 !irq)
    else $error("irq stays after ack");
  a_chan_steer: assert property (analog_ctrl.neg_from_chan |-> !$past(converter_enable))
    else $error("channel mux used while converter on");
  a_chan_copy: assert property (analog_ctrl.neg_from_chan
    |-> analog_ctrl.neg_channel == $past(channel_select_bits)) else $error("wrong channel");
  a_buf_neg: assert property (analog_ctrl.neg_buf_off && $past(analog_ctrl.neg_buf_off)
    |-> !pin_digital_read[1]) else $error("negative pin reads one while disabled");
  a_buf_pos: assert property (analog_ctrl.pos_buf_off && $past(analog_ctrl.pos_buf_off)
    |-> !pin_digital_read[0]) else $error("positive pin reads one while disabled");
  a_ats_write: assert property ($changed(auto_trigger_source_select)
    |-> $past(acc && pwrite && paddr == 8'h00) || $past(acc && pwrite && paddr == 8'h00, 2))
    else $error("trigger source moved without write");
  a_power_write: assert property ($changed(analog_ctrl.power_off)
    |-> $past(acc && pwrite && paddr == 8'h04) || $past(acc && pwrite && paddr == 8'h04, 2))
    else $error("power off moved without write");
  a_capture_src: assert property ($rose(capture_out)
    |-> $past(comp_raw, 2) || $past(comp_raw, 3) || $past(comp_raw, 4))
    else $error("capture rose without comparator high");
  c_irq_rise: cover property ($rose(irq));
  c_irq_ack: cover property (irq && irq_ack);
  c_slverr: cover property (pslverr);
  c_capture: cover property ($rose(capture_out));
endmodule : acm_top_sva
bind acm_top acm_top_sva i_acm_top_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .comp_raw(comp_raw), .converter_enable(converter_enable),
  .channel_select_bits(channel_select_bits), .global_irq_enable(global_irq_enable),
  .irq_ack(irq_ack), .analog_ctrl(analog_ctrl), .capture_out(capture_out),
  .pin_digital_read(pin_digital_read), .irq(irq),
  .auto_trigger_source_select(auto_trigger_source_select));
`default_nettype wire

// ==== sim/acm_analog_model.sv ====
// behavioural analog front end: comparator, input steering and pin buffers
`default_nettype none
module acm_analog_model
  import acm_pkg::*;
#(
  parameter logic [7:0] BANDGAP_LEVEL = 8'h80 // internal reference level
) (
  input  wire acm_analog_s     ctrl,           // controls from the block
  input  wire logic [7:0]      pos_level,      // positive pin voltage
  input  wire logic [7:0]      neg_level,      // negative pin voltage
  input  wire logic [7:0][7:0] chan_level,     // analog channel voltages
  input  wire logic [1:0]      pin_level,      // pin logic levels
  output logic                 comp_raw,       // comparator output
  output logic [1:0]           pin_digital_in  // pin buffer outputs
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] pos_eff; // voltage seen on the positive side
  logic [7:0] neg_eff; // voltage seen on the negative side
  // comparator with its input selection
  always_comb begin
    pos_eff = ctrl.bandgap_pos ? BANDGAP_LEVEL : pos_level;
    neg_eff = ctrl.neg_from_chan ? chan_level[ctrl.neg_channel] : neg_level;
    comp_raw = !ctrl.power_off && (pos_eff > neg_eff);
  end
  // a disabled buffer gives garbage: the inverse, so the block must gate it
  always_comb begin
    pin_digital_in[1] = ctrl.neg_buf_off ? ~pin_level[1] : pin_level[1];
    pin_digital_in[0] = ctrl.pos_buf_off ? ~pin_level[0] : pin_level[0];
  end
endmodule : acm_analog_model
`default_nettype wire

// ==== sim/acm_top_tb.sv ====
// self-checking testbench for the comparator event block
`default_nettype none
module acm_top_tb;
  import acm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] BG = 8'h80; // reference level of the model
  logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, conv_en, gie;
  logic irq_ack, comp_raw, capture_out, irq;
  logic [7:0] paddr, pos_v, neg_v, m_mx, m_cs, m_bd;
  logic [31:0] pwdata, prdata, q, d, seed;
  logic [7:0][7:0] chan_v;
  logic [2:0] sel, ats;
  logic [1:0] pin_lv, pin_in, pin_rd;
  logic e, m_res, m_flag;
  acm_analog_s actl;
  int n_mismatch = 0, comparisons = 0, i;
  always #12.5 pclk = ~pclk;
  acm_top i_acm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comp_raw(comp_raw), .pin_digital_in(pin_in),
    .converter_enable(conv_en), .channel_select_bits(sel), .global_irq_enable(gie),
    .irq_ack(irq_ack), .analog_ctrl(actl), .capture_out(capture_out),
    .pin_digital_read(pin_rd), .auto_trigger_source_select(ats), .irq(irq));
  acm_analog_model #(.BANDGAP_LEVEL(BG)) i_acm_analog_model (.ctrl(actl),
    .pos_level(pos_v), .neg_level(neg_v), .chan_level(chan_v), .pin_level(pin_lv),
    .comp_raw(comp_raw), .pin_digital_in(pin_in));
  // verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  // compare one value
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    comparisons++;
    if (g !== ex) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, ex, g);
    end
  endtask : chk
  // one apb transfer, waiting boundedly for pready
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      chk("pready", 1, pready);
      results();
    end else begin
      q = prdata; e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
    end
  endtask : apb
  // read a register and compare, also checking no error
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(a, 1'b0, 32'h0);
    chk(nm, ex, q);
    chk("slverr", 0, e);
  endtask : rd
  // let the comparator settle, then update the expected result and flag
  task automatic settle();
    int p, n, md;
    logic r;
    repeat (6) @(posedge pclk);
    p = m_cs[6] ? BG : pos_v;
    n = (m_mx[6] && !conv_en) ? chan_v[sel] : neg_v;
    r = !m_cs[7] && p > n;
    md = m_cs[1:0];
    if (r != m_res && (md == 0 || (md == 3 && r) || (md == 2 && !r))) m_flag = 1'b1;
    m_res = r;
  endtask : settle
  // compare the outputs and the control/status and interrupt registers against the model
  task automatic check_all();
    logic fc;
    fc = m_mx[6] && !conv_en;
    rd("ctrl_stat", 8'h04, {m_cs[7:6], m_res, m_flag, m_cs[3:0]});
    rd("irq_stat", 8'h0C, m_flag);
    rd("irq_en", 8'h14, m_cs[3]);
    rd("irq_clear", 8'h10, 0);
    chk("irq", m_flag && m_cs[3] && gie, irq);
    chk("capture", m_cs[2] && m_res, capture_out);
    chk("pin_read", pin_lv & ~m_bd[1:0], pin_rd);
    chk("trig_src", m_mx[2:0], ats);
    chk("analog", {m_cs[7:6], fc, fc ? sel : 3'h0, m_bd[1:0]}, actl & (fc ? 8'hFF : 8'hE3));
  endtask : check_all
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(a, 1'b1, wd);
  endtask : wr
  initial begin
    seed = 32'h727712d9;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; conv_en = 1'b0; gie = 1'b0; irq_ack = 1'b0; sel = 3'h0;
    pos_v = 8'h00; neg_v = 8'h00; chan_v = '0; pin_lv = 2'h0;
    m_mx = 8'h00; m_cs = 8'h00; m_bd = 8'h00; m_res = 1'b0; m_flag = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, read-only bits and unmapped access
    check_all();
    rd("mux_ctrl", 8'h00, 0);
    rd("buf_dis", 8'h08, 0);
    apb(8'h20, 1'b0, 32'h0);
    chk("unmapped_rd", 0, q);
    chk("unmapped_err", 1, e);
    wr(8'h08, 32'hFFFFFFFF);
    m_bd = 8'h03;
    rd("buf_dis", 8'h08, 3);
    wr(8'h00, 32'hFFFFFFFF);
    m_mx = 8'h47;
    rd("mux_ctrl", 8'h00, 32'h47);
    $display("register test done");
    // random voltages and steering, result compared each time
    for (i = 0; i < 16; i++) begin
      pos_v <= $random(seed); neg_v <= $random(seed); sel <= $random(seed);
      chan_v <= {$random(seed), $random(seed)}; conv_en <= $random(seed);
      pin_lv <= $random(seed);
      d = $random(seed);
      wr(8'h00, d);
      m_mx = d[7:0] & 8'h47;
      wr(8'h08, d >> 8);
      m_bd = d[15:8] & 8'h03;
      wr(8'h04, d[23:16] & 8'h44);
      m_cs = d[23:16] & 8'h44;
      settle();
      wr(8'h10, 32'h1);
      m_flag = 1'b0;
      check_all();
    end
    $display("steering test done");
    // every event mode, interrupt, vector ack and write-one clear
    wr(8'h00, 32'h0);
    m_mx = 8'h00;
    for (i = 0; i < 4; i++) begin
      gie <= (i != 2);
      wr(8'h04, i);
      m_cs = i;
      pos_v <= 8'h10; neg_v <= 8'h20;
      settle();
      wr(8'h10, 32'h1);
      m_flag = 1'b0;
      wr(8'h14, 32'h1);
      m_cs[3] = 1'b1;
      pos_v <= 8'h30;
      settle();
      check_all();
      irq_ack <= 1'b1;
      @(posedge pclk);
      irq_ack <= 1'b0;
      m_flag = 1'b0;
      check_all();
      neg_v <= 8'h40;
      settle();
      check_all();
      wr(8'h04, 8'h18 | i);
      m_flag = 1'b0;
      check_all();
      wr(8'h14, 32'h0);
      m_cs[3] = 1'b0;
    end
    $display("event test done");
    // raise the result, then clear the flag so the power edge shows
    pos_v <= 8'h50;
    settle();
    wr(8'h10, 32'h1);
    m_flag = 1'b0;
    // power off forces the result low and can itself make an edge
    for (i = 0; i < 2; i++) begin
      wr(8'h04, i ? 8'h00 : 8'h80);
      m_cs = i ? 8'h00 : 8'h80;
      settle();
      check_all();
    end
    $display("power test done");
    results();
  end
endmodule : acm_top_tb
`default_nettype wire
